// *** addr_mode_pkg.sv ***
// Package with constants and types for the switch-driven address mode selector.
package addr_mode_pkg;

  // ==========================================================================
  // Rotary codes that select a mode while the mode switch is on, and the static last byte at rotary zero.
  // ==========================================================================
  localparam logic [6:0] ROT_RESTORE = 7'h00; // Default-address restore code.
  localparam logic [6:0] ROT_DHCP = 7'h28; // Forty: DHCP addressing.
  localparam logic [6:0] ROT_PROG = 7'h32; // Fifty: tool programmed addressing.
  localparam logic [6:0] ROT_ONESHOT = 7'h3C; // Sixty: one-shot DHCP addressing.
  localparam logic [6:0] ROT_FACTORY = 7'h5A; // Ninety: factory reset.
  localparam logic [7:0] LAST_BYTE_ZERO_POS = 8'h64; // Hundred: last byte at rotary zero.

  // ==========================================================================
  // Default network settings loaded by the restore selection.
  // ==========================================================================
  localparam logic [31:0] DEF_IP = 32'hC0A801FE; // 192.168.1.254.
  localparam logic [31:0] DEF_MASK = 32'hFFFFFF00; // 255.255.255.0.
  localparam logic [31:0] DEF_GW = 32'hC0A80101; // 192.168.1.1.

  // ==========================================================================
  // Timing: settle time after reset before the switches are sampled.
  // ==========================================================================
  localparam int CLK_HZ = 20000000; // System clock rate.
  localparam int SETTLE_US = 10; // Switch settle time in microseconds.
  localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1000000)); // Cycles to wait.

  // Addressing modes decoded from the switches.
  typedef enum logic [2:0] {
    MODE_RESTORE, MODE_DHCP, MODE_PROG, MODE_ONESHOT, MODE_FACTORY, MODE_STATIC, MODE_INVALID
  } addrMode_t;

  // Network settings carried together.
  typedef struct packed {
    logic [31:0] ip;
    logic [31:0] mask;
    logic [31:0] gw;
  } netCfg_t;

endpackage : addr_mode_pkg

// *** switch_address_mode_select.sv ***
// Power-up decoder of rotary and DIP switches into an addressing mode and network settings.
// Contract
// - Restore code loads fixed default IP settings
// - Restore applies only after supply reset
// - Code forty selects DHCP addressing
// - Code fifty selects tool programmed addressing
// - Code sixty selects one-shot DHCP
// - Code ninety performs factory reset
// - Static mode: rotary sets last byte
// - Static zero gives last byte hundred
// - Last byte zero is never accepted
// - Static mode takes rest from storage, locked
// - Static address is never written to storage
// - New switches take effect after reset only
// - DHCP mode saves received address and mask
// - Other modes load settings from storage
// - Programming mode reads settings from storage
// - One-shot mode requests until address assigned
// - One-shot assignment is saved, client stops
// - Saved one-shot address stops further requests
// - Factory reset restores defaults, erases flash
module switch_address_mode_select
  import addr_mode_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC // Settle wait, shortenable in simulation.
) (
  input wire logic clk, // 20 MHz system clock.
  input wire logic rst, // Synchronous active-high supply reset.
  input wire logic [3:0] rotTens, // Tens rotary switch, asynchronous pin.
  input wire logic [3:0] rotUnits, // Units rotary switch, asynchronous pin.
  input wire logic [4:0] dipSw, // DIP switches 1..5, bit 4 is the mode switch.
  input wire netCfg_t storedCfg, // Settings held in non-volatile memory.
  input wire logic storedValid, // Storage holds an assigned address.
  input wire logic leaseValid, // DHCP client received an address.
  input wire netCfg_t leaseCfg, // Settings received from the server.
  input wire logic assignedValid, // Address assigned by any party in one-shot mode.
  input wire netCfg_t assignedCfg, // Settings assigned in one-shot mode.
  output addrMode_t addrMode, // Decoded addressing mode.
  output logic modeValid, // Mode and settings are valid.
  output netCfg_t activeCfg, // Network settings in use.
  output logic autoNeg, // Auto-negotiation enable.
  output logic cable_crossover_detect, // Crossover detection enable.
  output logic fast_startup_feature, // Fast startup enable.
  output logic cfgLocked, // Settings may not be changed by tools.
  output logic dhcpRequest, // DHCP client runs.
  output logic nvWrite, // One-cycle pulse that stores nvData.
  output netCfg_t nvData, // Settings to store.
  output logic factoryErase // Pulse that erases flash and restores defaults.
);

  // ==========================================================================
  // Pin synchronisers.
  // ==========================================================================
  logic [12:0] pinMeta_q; // First stage, read only by the second stage.
  logic [12:0] pinSync_q; // Second stage, safe for logic.
  logic [12:0] pinSync_d;

  // The switch pins cross into the clock domain through two flops.
  always_comb begin
    pinSync_d = pinMeta_q;
  end

  // Registers the synchroniser stages.
  always_ff @(posedge clk) begin
    pinMeta_q <= {rotTens, rotUnits, dipSw};
    pinSync_q <= pinSync_d;
  end

  // ==========================================================================
  // Decoding helpers.
  // ==========================================================================
  // Forms the rotary value from both decimal switches.
  function automatic logic [6:0] rotValue(input logic [3:0] tens, input logic [3:0] units);
    logic [6:0] t;
    t = {3'h0, tens};
    rotValue = 7'((t << 3) + (t << 1) + {3'h0, units});
  endfunction : rotValue

  // Maps switches onto a mode, looking only at the switches each mode needs.
  function automatic addrMode_t decodeMode(input logic [6:0] rot, input logic [4:0] dip);
    decodeMode = MODE_INVALID;
    if (dip[4]) begin
      case (rot)
        ROT_RESTORE: decodeMode = (dip[3:2] == 2'h0) ? MODE_RESTORE : MODE_INVALID;
        ROT_DHCP: decodeMode = MODE_DHCP;
        ROT_PROG: decodeMode = MODE_PROG;
        ROT_ONESHOT: decodeMode = MODE_ONESHOT;
        ROT_FACTORY: decodeMode = MODE_FACTORY;
        // Any other code with the mode switch on is left undefined.
        default: decodeMode = MODE_INVALID;
      endcase
    end else if (rot != 7'h00) begin
      decodeMode = MODE_STATIC;
    end else if (dip[3:2] == 2'h0) begin
      decodeMode = MODE_STATIC;
    end
    // DIP switches 1 and 2 are never looked at.
  endfunction : decodeMode

  // ==========================================================================
  // Power-up sequencer.
  // ==========================================================================
  typedef enum logic [1:0] {ST_SETTLE, ST_SAMPLE, ST_RUN} seqState_t;
  seqState_t state_q, state_d; // Sequencer state.
  logic [15:0] settle_q, settle_d; // Settle counter.
  logic [6:0] rot_q, rot_d; // Rotary value latched at power-up.
  logic [4:0] dip_q, dip_d; // DIP pattern latched at power-up.
  addrMode_t mode_q, mode_d; // Latched mode.
  netCfg_t cfg_q, cfg_d; // Active settings.
  logic saved_q, saved_d; // One-shot address saved, client halted.
  logic wr_q, wr_d; // Storage write pulse.
  netCfg_t nvd_q, nvd_d; // Storage write data.
  logic erase_q, erase_d; // Factory erase pulse.

  // Next-state logic: switches are read once, after reset, then frozen.
  always_comb begin
    state_d = state_q;
    settle_d = settle_q;
    rot_d = rot_q;
    dip_d = dip_q;
    mode_d = mode_q;
    cfg_d = cfg_q;
    saved_d = saved_q;
    wr_d = 1'b0;
    nvd_d = nvd_q;
    erase_d = 1'b0;
    case (state_q)
      ST_SETTLE: begin
        // Waits for the synchroniser and switch contacts to settle.
        if (settle_q >= 16'(SETTLE_CYCLES - 1)) begin
          state_d = ST_SAMPLE;
        end else begin
          settle_d = settle_q + 16'h1;
        end
      end
      ST_SAMPLE: begin
        // Single sample; later switch moves are ignored until reset.
        rot_d = rotValue(pinSync_q[12:9], pinSync_q[8:5]);
        dip_d = pinSync_q[4:0];
        mode_d = decodeMode(rot_d, dip_d);
        saved_d = storedValid;
        state_d = ST_RUN;
        case (mode_d)
          MODE_RESTORE: begin
            cfg_d = '{ip: DEF_IP, mask: DEF_MASK, gw: DEF_GW};
          end
          MODE_FACTORY: begin
            cfg_d = '{ip: DEF_IP, mask: DEF_MASK, gw: DEF_GW};
            erase_d = 1'b1;
          end
          MODE_STATIC: begin
            cfg_d = storedCfg;
            cfg_d.ip[7:0] = (rot_d == 7'h00) ? LAST_BYTE_ZERO_POS : {1'b0, rot_d};
          end
          default: begin
            cfg_d = storedCfg;
          end
        endcase
      end
      ST_RUN: begin
        // Only a DHCP lease or the first one-shot assignment updates the settings.
        if (mode_q == MODE_DHCP && leaseValid) begin
          cfg_d = leaseCfg;
          wr_d = 1'b1;
          nvd_d = leaseCfg;
        end else if (mode_q == MODE_ONESHOT && !saved_q && assignedValid) begin
          cfg_d = assignedCfg;
          saved_d = 1'b1;
          wr_d = 1'b1;
          nvd_d = assignedCfg;
        end
        // Static mode never asserts a write.
      end
      default: begin
        state_d = ST_SETTLE;
      end
    endcase
  end

  // Registers sequencer state; reset restarts the power-up sampling.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_SETTLE;
      settle_q <= 16'h0;
      rot_q <= 7'h00;
      dip_q <= 5'h00;
      mode_q <= MODE_INVALID;
      cfg_q <= '0;
      saved_q <= 1'b0;
      wr_q <= 1'b0;
      nvd_q <= '0;
      erase_q <= 1'b0;
    end else begin
      state_q <= state_d;
      settle_q <= settle_d;
      rot_q <= rot_d;
      dip_q <= dip_d;
      mode_q <= mode_d;
      cfg_q <= cfg_d;
      saved_q <= saved_d;
      wr_q <= wr_d;
      nvd_q <= nvd_d;
      erase_q <= erase_d;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  logic running; // Sequencer has sampled the switches.
  assign running = (state_q == ST_RUN);
  assign addrMode = mode_q;
  assign modeValid = running && (mode_q != MODE_INVALID);
  assign activeCfg = cfg_q;
  assign autoNeg = running && (mode_q == MODE_RESTORE);
  assign cable_crossover_detect = running && (mode_q == MODE_RESTORE);
  assign fast_startup_feature = 1'b0;
  assign cfgLocked = running && (mode_q == MODE_STATIC);
  assign dhcpRequest = running && ((mode_q == MODE_DHCP) ||
                       (mode_q == MODE_ONESHOT && !saved_q));
  assign nvWrite = wr_q;
  assign nvData = nvd_q;
  assign factoryErase = erase_q;

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  static_no_write_a: assert property (@(posedge clk) disable iff (rst)
    (mode_q == MODE_STATIC) |-> !nvWrite) else $error("Static mode wrote storage.");
  static_byte_nonzero_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_STATIC) |-> (cfg_q.ip[7:0] != 8'h00))
    else $error("Static last byte is zero.");
  restore_values_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_RESTORE) |-> (cfg_q.ip == DEF_IP && cfg_q.gw == DEF_GW && autoNeg))
    else $error("Restore defaults wrong.");
  mode_frozen_a: assert property (@(posedge clk) disable iff (rst)
    running |=> $stable(mode_q)) else $error("Mode changed without reset.");
  dhcp_save_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_DHCP && leaseValid) |=> (nvWrite && nvData == $past(leaseCfg)))
    else $error("DHCP lease not saved.");
  oneshot_stop_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_ONESHOT && !saved_q && assignedValid) |=> (nvWrite && !dhcpRequest))
    else $error("One-shot did not save and stop.");
  oneshot_saved_a: assert property (@(posedge clk) disable iff (rst)
    saved_q |-> !(dhcpRequest && mode_q == MODE_ONESHOT)) else $error("Requests after save.");
  factory_erase_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_SAMPLE && mode_d == MODE_FACTORY) |=> factoryErase)
    else $error("Factory erase missing.");
  fast_off_a: assert property (@(posedge clk) disable iff (rst)
    !fast_startup_feature) else $error("Fast startup enabled.");
  // Sampling happens once and leads straight to the run state.
  sample_once_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_SAMPLE) |=> (state_q == ST_RUN)) else $error("Sampling not single.");
  // The static last byte follows the rotary value, with zero mapped to one hundred.
  static_byte_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_STATIC) |->
    (cfg_q.ip[7:0] == ((rot_q == 7'h00) ? LAST_BYTE_ZERO_POS : {1'b0, rot_q})))
    else $error("Static last byte wrong.");
  // Static settings are locked and do not move while running.
  static_locked_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_STATIC) |=> (cfgLocked && $stable(cfg_q)))
    else $error("Static settings not locked.");
  // Restore only comes from rotary zero, mode switch on, switches 4 and 3 off.
  restore_gate_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_RESTORE) |-> (rot_q == ROT_RESTORE && dip_q[4:2] == 3'h4))
    else $error("Restore from wrong switches.");
  // DHCP, programming and one-shot modes start from the stored settings.
  stored_load_a: assert property (@(posedge clk) disable iff (rst)
    (state_q == ST_SAMPLE && (mode_d == MODE_DHCP || mode_d == MODE_PROG ||
    mode_d == MODE_ONESHOT)) |=> (activeCfg == $past(storedCfg)))
    else $error("Stored settings not loaded.");
  // One-shot mode keeps requesting until an address is saved.
  oneshot_req_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_ONESHOT && !saved_q) |-> dhcpRequest)
    else $error("One-shot request missing.");
  // Factory reset shows the default address and runs no client.
  factory_cfg_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_FACTORY) |-> (cfg_q.ip == DEF_IP && cfg_q.mask == DEF_MASK &&
    !dhcpRequest)) else $error("Factory settings wrong.");
  // The erase pulse comes only from the factory selection.
  erase_only_a: assert property (@(posedge clk) disable iff (rst)
    factoryErase |-> (mode_q == MODE_FACTORY)) else $error("Erase outside factory mode.");
  // Unlisted combinations run no client, write nothing and stay unlocked.
  invalid_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (running && mode_q == MODE_INVALID) |-> (!dhcpRequest && !nvWrite && !cfgLocked))
    else $error("Invalid mode is active.");

  // ==========================================================================
  // Cover properties.
  // ==========================================================================
  cover_static_c: cover property (@(posedge clk) disable iff (rst) running && mode_q == MODE_STATIC);
  cover_oneshot_c: cover property (@(posedge clk) disable iff (rst)
    mode_q == MODE_ONESHOT && assignedValid && !saved_q && running);
  cover_factory_c: cover property (@(posedge clk) disable iff (rst) factoryErase);
  // Covers the lease path and the restore selection.
  cover_dhcp_c: cover property (@(posedge clk) disable iff (rst)
    running && mode_q == MODE_DHCP && leaseValid);
  cover_restore_c: cover property (@(posedge clk) disable iff (rst)
    running && mode_q == MODE_RESTORE);

endmodule : switch_address_mode_select

// *** far_side_model.sv ***
// Far-side model: DHCP server, configuration tool and non-volatile settings store.
module far_side_model
  import addr_mode_pkg::*;
#(
  parameter netCfg_t INIT_CFG = '0 // Storage content at power-on.
) (
  input wire logic clk, // System clock.
  input wire logic dhcpRequest, // The client is asking for an address.
  input wire logic nvWrite, // Store strobe from the block.
  input wire netCfg_t nvData, // Settings to store.
  input wire logic factoryErase, // Erase strobe from the block.
  input wire logic offerLease, // Bench lets the server answer a request.
  input wire logic offerAssign, // Bench lets a tool assign an address.
  input wire netCfg_t offerCfg, // Settings handed out by server or tool.
  output netCfg_t storedCfg, // Stored settings.
  output logic storedValid, // Storage holds an assigned address.
  output logic leaseValid, // One-cycle lease strobe.
  output netCfg_t leaseCfg, // Lease settings, scrambled while idle.
  output logic assignedValid, // One-cycle assignment strobe.
  output netCfg_t assignedCfg // Assigned settings, scrambled while idle.
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Storage and strobes.
  // ==========================================================================
  // The store starts with known content and is empty of any assignment.
  initial begin
    storedCfg = INIT_CFG;
    storedValid = 1'b0;
    leaseValid = 1'b0;
    assignedValid = 1'b0;
  end
  // The store keeps its content through resets, as flash does.
  always @(posedge clk) begin
    leaseValid <= offerLease & dhcpRequest; // The server answers only a requesting client.
    assignedValid <= offerAssign;
    if (factoryErase === 1'b1) begin
      storedCfg <= '0;
      storedValid <= 1'b0;
    end else if (nvWrite === 1'b1) begin
      storedCfg <= nvData;
      storedValid <= 1'b1;
    end
  end
  // Idle data lines carry the inverse so a stale value never passes for a fresh one.
  assign leaseCfg = leaseValid ? offerCfg : ~offerCfg;
  assign assignedCfg = assignedValid ? offerCfg : ~offerCfg;
endmodule : far_side_model

// *** tb_top.sv ***
// Self-checking testbench for the switch-driven address mode selector.
module tb_top
  import addr_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 4; // Shortened settle wait.
  localparam netCfg_t INIT = {32'h0A000005, 32'hFFFF0000, 32'h0A000001}; // Preloaded storage.
  localparam netCfg_t LEASE = {32'h0A0A0A21, 32'hFFFFFF00, 32'h0A0A0A01}; // Server lease.
  localparam netCfg_t DEFS = {DEF_IP, DEF_MASK, DEF_GW}; // Restore settings.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] rotTens = 4'h0;
  logic [3:0] rotUnits = 4'h0;
  logic [4:0] dipSw = 5'h00;
  logic offerLease = 1'b0;
  logic offerAssign = 1'b0;
  netCfg_t offerCfg = LEASE;
  netCfg_t storedCfg, leaseCfg, assignedCfg, activeCfg, nvData, lastNv;
  logic storedValid, leaseValid, assignedValid, modeValid, autoNeg, crossDet, fastStart;
  logic cfgLocked, dhcpRequest, nvWrite, factoryErase;
  addrMode_t addrMode;
  int bad_count = 0;
  int num_checks = 0;
  int nvCount = 0;
  int eraseCount = 0;
  int n0;
  int vals[3] = '{1, 73, 99};
  always #25 clk = ~clk;
  switch_address_mode_select #(.SETTLE_CYCLES(SC)) u_dut (.clk(clk), .rst(rst),
    .rotTens(rotTens), .rotUnits(rotUnits), .dipSw(dipSw), .storedCfg(storedCfg),
    .storedValid(storedValid), .leaseValid(leaseValid), .leaseCfg(leaseCfg),
    .assignedValid(assignedValid), .assignedCfg(assignedCfg), .addrMode(addrMode),
    .modeValid(modeValid), .activeCfg(activeCfg), .autoNeg(autoNeg),
    .cable_crossover_detect(crossDet), .fast_startup_feature(fastStart),
    .cfgLocked(cfgLocked), .dhcpRequest(dhcpRequest), .nvWrite(nvWrite), .nvData(nvData),
    .factoryErase(factoryErase));
  far_side_model #(.INIT_CFG(INIT)) u_far (.clk(clk), .dhcpRequest(dhcpRequest),
    .nvWrite(nvWrite), .nvData(nvData), .factoryErase(factoryErase),
    .offerLease(offerLease), .offerAssign(offerAssign), .offerCfg(offerCfg),
    .storedCfg(storedCfg), .storedValid(storedValid), .leaseValid(leaseValid),
    .leaseCfg(leaseCfg), .assignedValid(assignedValid), .assignedCfg(assignedCfg));
  // Counts the one-cycle strobes so no pulse is missed between checks.
  always @(posedge clk) begin
    if (nvWrite === 1'b1) begin
      nvCount++;
      lastNv = nvData;
    end
    if (factoryErase === 1'b1) begin
      eraseCount++;
    end
  end
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Supply reset with new switch positions, then waits until the mode is running.
  task automatic power_up(input logic [3:0] t, input logic [3:0] u, input logic [4:0] d);
    @(posedge clk);
    rst <= 1'b1;
    rotTens <= t;
    rotUnits <= u;
    dipSw <= d;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (SC + 4) @(posedge clk);
    #10;
  endtask : power_up
  // One-cycle request to the server (lease) or to a tool (assign).
  task automatic offer(input logic lease, input netCfg_t cfg);
    @(posedge clk);
    offerCfg <= cfg;
    offerLease <= lease;
    offerAssign <= ~lease;
    @(posedge clk);
    offerLease <= 1'b0;
    offerAssign <= 1'b0;
    repeat (4) @(posedge clk);
    #10;
  endtask : offer
  // Ends the run with the verdict.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  // Main sequence of tests.
  initial begin
    foreach (vals[i]) begin
      power_up(4'(vals[i] / 10), 4'(vals[i] % 10), 5'h0F);
      chk(96'(addrMode), 96'(MODE_STATIC));
      chk(96'({modeValid, dhcpRequest, nvWrite}), 96'h4);
      chk(activeCfg, {INIT.ip[31:8], 8'(vals[i]), INIT.mask, INIT.gw});
      chk(96'(cfgLocked), 96'h1);
    end
    n0 = nvCount;
    offer(1'b0, LEASE);
    chk(96'(nvCount), 96'(n0));
    @(posedge clk);
    rotTens <= 4'h4;
    repeat (6) @(posedge clk);
    #10;
    chk(96'(addrMode), 96'(MODE_STATIC));
    power_up(4'h0, 4'h0, 5'h00);
    chk(activeCfg, {INIT.ip[31:8], 8'h64, INIT.mask, INIT.gw});
    $display("Test static done");
    power_up(4'h0, 4'h0, 5'h13);
    chk(96'(addrMode), 96'(MODE_RESTORE));
    chk(activeCfg, DEFS);
    chk(96'({autoNeg, crossDet, fastStart}), 96'h6);
    chk(96'({modeValid, cfgLocked, dhcpRequest}), 96'h4);
    power_up(4'h0, 4'h0, 5'h18);
    chk(96'(addrMode), 96'(MODE_INVALID));
    chk(96'({modeValid, dhcpRequest, cfgLocked, autoNeg}), 96'h0);
    power_up(4'h0, 4'h0, 5'h04);
    chk(96'(addrMode), 96'(MODE_INVALID));
    $display("Test restore done");
    power_up(4'h4, 4'h0, 5'h1F);
    chk(96'({addrMode, dhcpRequest}), 96'({MODE_DHCP, 1'b1}));
    n0 = nvCount;
    offer(1'b1, LEASE);
    chk(96'(nvCount), 96'(n0 + 1));
    chk(lastNv, LEASE);
    chk(activeCfg, LEASE);
    power_up(4'h5, 4'h0, 5'h10);
    chk(96'(addrMode), 96'(MODE_PROG));
    chk(activeCfg, LEASE);
    $display("Test dhcp done");
    n0 = eraseCount;
    power_up(4'h9, 4'h0, 5'h10);
    chk(96'(addrMode), 96'(MODE_FACTORY));
    chk(96'(eraseCount), 96'(n0 + 1));
    chk(activeCfg, DEFS);
    power_up(4'h6, 4'h0, 5'h10);
    chk(96'({addrMode, dhcpRequest}), 96'({MODE_ONESHOT, 1'b1}));
    n0 = nvCount;
    offer(1'b0, INIT);
    chk(96'(nvCount), 96'(n0 + 1));
    chk(96'({dhcpRequest, storedValid}), 96'h1);
    offer(1'b0, LEASE);
    chk(96'(nvCount), 96'(n0 + 1));
    chk(96'(dhcpRequest), 96'h0);
    power_up(4'h6, 4'h0, 5'h10);
    chk(96'(dhcpRequest), 96'h0);
    $display("Test one-shot done");
    complete_run();
  end
endmodule : tb_top
